// ==== design/pxt_pkg.sv ====
// Purpose: shared constants, types and number conversions for the pixel transfer pipeline
// Assumes: components are float32 at the ports, Q16.16 signed fixed point inside
// Notes:   indices travel as Q16.16 fixed point; table entries are 32-bit words
package pxt_pkg;

  localparam int COMP_W = 32;
  localparam int FRAC_W = 16;
  localparam int LUT_AW = 4;
  localparam int LUT_DEPTH = 1 << LUT_AW;
  localparam int NTAB = 14;
  localparam int PROD_W = FRAC_W + LUT_AW + 1;

  localparam logic [31:0] ONE_FX = 32'h0001_0000;
  localparam logic [31:0] HALF_FX = 32'h0000_8000;
  localparam logic [31:0] SAT_FX = 32'h7fff_ffff;
  // float exponent at which the 24-bit mantissa lines up with Q16.16
  localparam logic [7:0] FX_EXP_ALIGN = 8'h86;
  localparam logic [7:0] FX_EXP_SAT = 8'h8d;
  localparam logic [7:0] FLT_EXP_OFS = 8'h6f;
  localparam logic [31:0] OUT_RST = 32'h0;

  // table numbers on the write port
  localparam logic [3:0] red_to_red_lut = 4'h0;
  localparam logic [3:0] green_to_green_lut = 4'h1;
  localparam logic [3:0] blue_to_blue_lut = 4'h2;
  localparam logic [3:0] alpha_to_alpha_lut = 4'h3;
  localparam logic [3:0] idx_to_red_lut = 4'h4;
  localparam logic [3:0] idx_to_green_lut = 4'h5;
  localparam logic [3:0] idx_to_blue_lut = 4'h6;
  localparam logic [3:0] idx_to_alpha_lut = 4'h7;
  localparam logic [3:0] idx_to_idx_lut = 4'h8;
  localparam logic [3:0] stencil_to_stencil_lut = 4'h9;
  localparam logic [3:0] ctab_red_lut = 4'ha;
  localparam logic [3:0] ctab_alpha_lut = 4'hd;

  localparam logic [2:0] SCL_DEPTH = 3'h4;

  typedef enum logic [2:0] {
    pxt_k_frgba = 3'h0,
    pxt_k_irgba = 3'h1,
    pxt_k_depth = 3'h2,
    pxt_k_cidx  = 3'h3,
    pxt_k_sidx  = 3'h4,
    pxt_k_ds    = 3'h5
  } pxt_kind_t;

  typedef enum logic [1:0] {
    pxt_d_raster   = 2'h0,
    pxt_d_texture  = 2'h1,
    pxt_d_readback = 2'h2
  } pxt_dest_t;

  typedef enum logic [2:0] {
    pxt_f_alpha                            = 3'h0,
    pxt_f_lum                              = 3'h1,
    pxt_f_lum_plus_alpha_format            = 3'h2,
    pxt_f_single_value_all_channels_format = 3'h3,
    pxt_f_rgb                              = 3'h4,
    pxt_f_rgba                             = 3'h5
  } pxt_ctab_fmt_t;

  // float32 to Q16.16, saturating, denormals read as zero
  function automatic logic [31:0] pxt_f2x(input logic [31:0] f);
    logic [31:0] mag;
    logic [7:0]  e;
    e = f[30:23];
    if (e == 8'h0) mag = 32'h0;
    else if (e > FX_EXP_SAT) mag = SAT_FX;
    else if (e >= FX_EXP_ALIGN) mag = {8'h0, 1'b1, f[22:0]} << (e - FX_EXP_ALIGN);
    else mag = {8'h0, 1'b1, f[22:0]} >> (FX_EXP_ALIGN - e);
    return f[31] ? (~mag + 32'h1) : mag;
  endfunction

  // Q16.16 to float32, mantissa truncated
  function automatic logic [31:0] pxt_x2f(input logic [31:0] x);
    logic [31:0] mag;
    logic [31:0] nrm;
    logic [4:0]  p;
    mag = x[31] ? (~x + 32'h1) : x;
    p = 5'h0;
    for (int i = 0; i < 32; i++) begin
      if (mag[i]) p = 5'(i);
    end
    nrm = mag << (5'd31 - p);
    if (mag == 32'h0) return 32'h0;
    return {x[31], {3'h0, p} + FLT_EXP_OFS, nrm[30:8]};
  endfunction

  function automatic logic [31:0] pxt_mul_fx(input logic [31:0] a, input logic [31:0] b);
    logic signed [63:0] p;
    p = $signed(a) * $signed(b);
    return p[47:16];
  endfunction

endpackage

// ==== design/pxt_lut_if.sv ====
// Purpose: carries one lookup address computation between the pipeline and its address unit
// Assumes: val is Q16.16, m1 is table size minus one
// Notes:   one instance per channel in the component map and colour table lookup stages
`timescale 1ns/1ps
`default_nettype none
interface pxt_lut_if;
  import pxt_pkg::*;
  logic [COMP_W-1:0] val;
  logic [LUT_AW-1:0] m1;
  logic [LUT_AW-1:0] addr;
  modport unit (input val, input m1, output addr);
  modport user (output val, output m1, input addr);
endinterface
`default_nettype wire

// ==== design/pxt_lut_addr.sv ====
// Purpose: clamp a component to [0,1], scale by size minus one, round to nearest
// Assumes: val is signed Q16.16
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module pxt_lut_addr (
  pxt_lut_if.unit lif
);
  import pxt_pkg::*;

  logic [FRAC_W:0]   clamped;
  logic [PROD_W-1:0] prod;

  always_comb begin
    if (lif.val[COMP_W-1]) clamped = '0;
    else if (lif.val >= ONE_FX) clamped = ONE_FX[FRAC_W:0];
    else clamped = lif.val[FRAC_W:0];
    prod = PROD_W'(clamped) * PROD_W'(lif.m1) + HALF_FX[PROD_W-1:0];
    lif.addr = prod[FRAC_W +: LUT_AW];
  end

endmodule // pxt_lut_addr
`default_nettype wire

// ==== design/pxt_pipe.sv ====
// Purpose: pixel transfer pipeline, one group per handshake, result registered
// Assumes: groups arrive unpacked and expanded; tables loaded over the write port
// Notes:   components float32 at the ports, indices Q16.16 at the output
// Behaviour
// R01 - every group is tagged as one of six kinds
// R02 - stages run in turn, skipped where inapplicable; integer quads pass untouched
// R03 - float quads and depth get per-channel signed scale then bias
// R04 - indices become fixed point; integer indices carry zero fraction
// R05 - index shifts left by shift when positive, else right, zero filled
// R06 - signed index offset is added after the shift
// R07 - colour map enable clamps quads to [0,1]; clear skips the lookup
// R08 - component address is clamped value times size minus one, rounded
// R09 - colour index converts for colour raster, texture, or non-index readback
// R10 - converting uses the integer index into four colour tables
// R11 - otherwise with colour map on: round, mask, replace by fixed entry
// R12 - index path keeps the group a colour index group
// R13 - stencil map on: mask integer index, replace with entry; else unchanged
// R14 - colour table only on float quads when enabled and width nonzero
// R15 - table format chooses which components get replaced
// R16 - colour table index: clamp, times width minus one, round
// R17 - one colour table enable bit, clear after reset
// R18 - stage order fixed; one group per valid handshake
// R19 - float32 components, fixed-point indices of configurable width; code fixes indices at Q16.16
`timescale 1ns/1ps
`default_nettype none
module pxt_pipe (
  input  wire logic                                      ref_clk,
  input  wire logic                                      rst_b,
  input  wire logic                                      in_valid,
  output logic                                           in_ready,
  input  wire pxt_pkg::pxt_kind_t                        in_kind,
  input  wire logic [3:0][pxt_pkg::COMP_W-1:0]           in_comp,
  input  wire logic                                      in_idx_float,
  output logic                                           out_valid,
  input  wire logic                                      out_ready,
  output pxt_pkg::pxt_kind_t                             out_kind,
  output logic [3:0][pxt_pkg::COMP_W-1:0]                out_comp,
  input  wire logic [4:0][pxt_pkg::COMP_W-1:0]           scale_f,
  input  wire logic [4:0][pxt_pkg::COMP_W-1:0]           bias_f,
  input  wire logic [5:0]                                index_shift,
  input  wire logic [15:0]                               index_offset,
  input  wire logic                                      map_color,
  input  wire logic                                      map_stencil,
  input  wire pxt_pkg::pxt_dest_t                        dest,
  input  wire logic                                      raster_rgba,
  input  wire logic                                      readback_index_fmt,
  input  wire logic                                      ctab_en_wr,
  input  wire logic                                      ctab_en_wdata,
  output logic                                           ctab_en,
  input  wire pxt_pkg::pxt_ctab_fmt_t                    ctab_fmt,
  input  wire logic [pxt_pkg::LUT_AW:0]                  ctab_width,
  input  wire logic [pxt_pkg::NTAB-1:0][pxt_pkg::LUT_AW-1:0] tab_size_m1,
  input  wire logic                                      tab_wr_en,
  input  wire logic [3:0]                                tab_wr_sel,
  input  wire logic [pxt_pkg::LUT_AW-1:0]                tab_wr_addr,
  input  wire logic [pxt_pkg::COMP_W-1:0]                tab_wr_data
);
  import pxt_pkg::*;

  logic [COMP_W-1:0]      lut_mem [NTAB][LUT_DEPTH];
  logic                   ctab_en_ff;
  logic                   out_valid_ff;
  pxt_kind_t              out_kind_ff;
  logic [3:0][COMP_W-1:0] out_comp_ff;
  pxt_kind_t              nxt_kind;
  logic [3:0][COMP_W-1:0] nxt_comp;

  logic [3:0][COMP_W-1:0] fx_in;
  logic [4:0][COMP_W-1:0] sc_fx;
  logic [4:0][COMP_W-1:0] bs_fx;
  logic [3:0][COMP_W-1:0] sb;
  logic [COMP_W-1:0]      idx_src;
  logic [COMP_W-1:0]      idx_fx;
  logic [5:0]             sh_mag;
  logic [COMP_W-1:0]      idx_sh;
  logic [COMP_W-1:0]      idx_off;
  logic [3:0][LUT_AW-1:0] cm_addr;
  logic [3:0][COMP_W-1:0] cl;
  logic                   need_rgba;
  logic [COMP_W-1:0]      idx_rnd;
  logic [LUT_AW-1:0]      ii_addr;
  logic [LUT_AW-1:0]      ci_addr;
  logic [COMP_W-1:0]      idx_res;
  logic [3:0][COMP_W-1:0] c2;
  pxt_kind_t              kind2;
  logic [LUT_AW-1:0]      st_addr;
  logic [COMP_W-1:0]      st_res;
  logic [LUT_AW-1:0]      ct_m1;
  logic [3:0][LUT_AW-1:0] ct_addr;
  logic                   ct_go;
  logic [3:0]             ct_rep;
  logic [3:0][3:0]        ct_src;
  logic [3:0][COMP_W-1:0] c3;

  // ---- table storage ----
  always_ff @(posedge ref_clk) begin
    if (tab_wr_en && (tab_wr_sel < 4'(NTAB))) begin
      lut_mem[tab_wr_sel][tab_wr_addr] <= tab_wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      ctab_en_ff <= 1'b0; // [R17]
    end else if (ctab_en_wr) begin
      ctab_en_ff <= ctab_en_wdata; // [R17]
    end
  end

  assign ctab_en = ctab_en_ff;

  // ---- scale and bias ----
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      sc_fx[i] = pxt_f2x(scale_f[i]);
      bs_fx[i] = pxt_f2x(bias_f[i]);
    end
    for (int i = 0; i < 4; i++) begin
      fx_in[i] = pxt_f2x(in_comp[i]); // [R19]
    end
  end

  always_comb begin
    sb = fx_in;
    case (in_kind) // [R01]
      pxt_k_frgba: begin
        for (int i = 0; i < 4; i++) begin
          sb[i] = pxt_mul_fx(fx_in[i], sc_fx[i]) + bs_fx[i]; // [R03]
        end
      end
      pxt_k_depth, pxt_k_ds: begin
        sb[0] = pxt_mul_fx(fx_in[0], sc_fx[SCL_DEPTH]) + bs_fx[SCL_DEPTH]; // [R03]
      end
      default: ;
    endcase
  end

  // ---- index arithmetic ----
  always_comb begin
    idx_src = (in_kind == pxt_k_ds) ? in_comp[1] : in_comp[0];
    if (in_idx_float) idx_fx = pxt_f2x(idx_src); // [R04]
    else idx_fx = {idx_src[COMP_W-FRAC_W-1:0], {FRAC_W{1'b0}}}; // [R04]
    sh_mag = index_shift[5] ? 6'(-index_shift) : index_shift;
    if ($signed(index_shift) > 6'sd0) idx_sh = idx_fx << sh_mag; // [R05]
    else idx_sh = idx_fx >> sh_mag; // [R05]
    idx_off = idx_sh + {index_offset, {FRAC_W{1'b0}}}; // [R06]
  end

  // ---- component to component lookup and address units ----
  for (genvar g = 0; g < 4; g++) begin : g_ch
    pxt_lut_if cm_if ();
    pxt_lut_if ct_if ();
    pxt_lut_addr u_cm (.lif(cm_if.unit));
    pxt_lut_addr u_ct (.lif(ct_if.unit));
    assign cm_if.val = sb[g]; // [R07]
    assign cm_if.m1 = tab_size_m1[g]; // [R08]
    assign cm_addr[g] = cm_if.addr;
    assign ct_if.val = c2[g]; // [R16]
    assign ct_if.m1 = ct_m1; // [R16]
    assign ct_addr[g] = ct_if.addr;
  end

  always_comb begin
    cl = sb;
    if ((in_kind == pxt_k_frgba) && map_color) begin // [R07]
      for (int i = 0; i < 4; i++) begin
        cl[i] = pxt_f2x(lut_mem[i][cm_addr[i]]); // [R08]
      end
    end
  end

  // ---- colour index lookup ----
  always_comb begin
    case (dest) // [R09]
      pxt_d_raster:   need_rgba = raster_rgba;
      pxt_d_texture:  need_rgba = 1'b1;
      pxt_d_readback: need_rgba = !readback_index_fmt;
      default:        need_rgba = 1'b0;
    endcase
  end

  always_comb begin
    c2 = cl;
    kind2 = in_kind;
    idx_res = idx_off;
    ci_addr = idx_off[FRAC_W +: LUT_AW];
    idx_rnd = idx_off + HALF_FX;
    ii_addr = idx_rnd[FRAC_W +: LUT_AW] & tab_size_m1[idx_to_idx_lut]; // [R11]
    if (in_kind == pxt_k_cidx) begin
      if (need_rgba) begin
        kind2 = pxt_k_frgba; // [R10]
        for (int i = 0; i < 4; i++) begin
          c2[i] = pxt_f2x(lut_mem[idx_to_red_lut + 4'(i)]
                          [ci_addr & tab_size_m1[idx_to_red_lut + 4'(i)]]); // [R10]
        end
      end else if (map_color) begin
        idx_res = pxt_f2x(lut_mem[idx_to_idx_lut][ii_addr]); // [R11]
      end
    end
  end

  // ---- stencil index lookup ----
  always_comb begin
    st_addr = idx_off[FRAC_W +: LUT_AW] & tab_size_m1[stencil_to_stencil_lut]; // [R13]
    st_res = idx_off;
    if (map_stencil) begin
      st_res = {lut_mem[stencil_to_stencil_lut][st_addr][COMP_W-FRAC_W-1:0],
                {FRAC_W{1'b0}}}; // [R13]
    end
  end

  // ---- colour table lookup ----
  always_comb begin
    ct_m1 = LUT_AW'(ctab_width - 1'b1);
    ct_go = (kind2 == pxt_k_frgba) && ctab_en_ff && (ctab_width != '0); // [R14]
    case (ctab_fmt) // [R15]
      pxt_f_alpha:                            ct_rep = 4'h8;
      pxt_f_lum:                              ct_rep = 4'h7;
      pxt_f_lum_plus_alpha_format:            ct_rep = 4'hf;
      pxt_f_single_value_all_channels_format: ct_rep = 4'hf;
      pxt_f_rgb:                              ct_rep = 4'h7;
      pxt_f_rgba:                             ct_rep = 4'hf;
      default:                                ct_rep = 4'h0;
    endcase
    for (int i = 0; i < 4; i++) begin
      if ((ctab_fmt == pxt_f_rgb) || (ctab_fmt == pxt_f_rgba)) begin
        ct_src[i] = ctab_red_lut + 4'(i); // [R15]
      end else if ((i == 3) && (ctab_fmt != pxt_f_single_value_all_channels_format)) begin
        ct_src[i] = ctab_alpha_lut; // [R15]
      end else begin
        ct_src[i] = ctab_red_lut; // [R15]
      end
    end
  end

  always_comb begin
    c3 = c2;
    if (ct_go) begin // [R14]
      for (int i = 0; i < 4; i++) begin
        if (ct_rep[i]) c3[i] = pxt_f2x(lut_mem[ct_src[i]][ct_addr[i]]); // [R16]
      end
    end
  end

  // ---- result assembly ----
  always_comb begin
    nxt_kind = kind2; // [R12]
    nxt_comp = '0;
    case (kind2)
      pxt_k_frgba: begin
        for (int i = 0; i < 4; i++) begin
          nxt_comp[i] = pxt_x2f(c3[i]); // [R19]
        end
      end
      pxt_k_irgba: nxt_comp = in_comp; // [R02]
      pxt_k_depth: nxt_comp[0] = pxt_x2f(sb[0]);
      pxt_k_cidx:  nxt_comp[0] = idx_res; // [R12]
      pxt_k_sidx:  nxt_comp[0] = st_res; // [R13]
      pxt_k_ds: begin
        nxt_comp[0] = pxt_x2f(sb[0]);
        nxt_comp[1] = st_res; // [R13]
      end
      default: nxt_kind = in_kind;
    endcase
  end

  // ---- output register and handshake ----
  assign in_ready = !out_valid_ff || out_ready; // [R18]

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_valid_ff <= 1'b0;
    end else if (in_ready) begin
      out_valid_ff <= in_valid; // [R18]
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      out_kind_ff <= pxt_k_frgba;
      out_comp_ff <= {4{OUT_RST}};
    end else if (in_valid && in_ready) begin
      out_kind_ff <= nxt_kind; // [R02]
      out_comp_ff <= nxt_comp; // [R02]
    end
  end

  assign out_valid = out_valid_ff;
  assign out_kind = out_kind_ff;
  assign out_comp = out_comp_ff;

endmodule // pxt_pipe
`default_nettype wire

// ==== tb/pxt_sink_model.sv ====
// Purpose: downstream sink that accepts finished pixel groups
// Assumes: one clock; ready may be throttled by the bench
// Notes:   stall leaves ready high only every other cycle
`timescale 1ns/1ps
`default_nettype none
module pxt_sink_model (
  input  wire logic ref_clk,
  input  wire logic stall,
  output logic      out_ready
);
  logic cnt_ff = 1'b0;
  always_ff @(posedge ref_clk) begin
    cnt_ff <= ~cnt_ff;
  end
  // throttled acceptance makes the pipeline hold its result
  assign out_ready = !stall || cnt_ff;
endmodule // pxt_sink_model
`default_nettype wire

// ==== tb/pxt_pipe_monitor.sv ====
// Purpose: port-level checks of the pixel transfer pipeline
// Assumes: bound to pxt_pipe; one clock, rst_b synchronous
// Notes:   handshake, pass-through, kind and enable checks
`timescale 1ns/1ps
`default_nettype none
module pxt_pipe_monitor (
  input wire logic                            ref_clk,
  input wire logic                            rst_b,
  input wire logic                            in_valid,
  input wire logic                            in_ready,
  input wire pxt_pkg::pxt_kind_t              in_kind,
  input wire logic [3:0][pxt_pkg::COMP_W-1:0] in_comp,
  input wire logic                            out_valid,
  input wire logic                            out_ready,
  input wire pxt_pkg::pxt_kind_t              out_kind,
  input wire logic [3:0][pxt_pkg::COMP_W-1:0] out_comp,
  input wire pxt_pkg::pxt_dest_t              dest,
  input wire logic                            readback_index_fmt,
  input wire logic                            ctab_en_wr,
  input wire logic                            ctab_en_wdata,
  input wire logic                            ctab_en
);
  import pxt_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire take = in_valid && in_ready;
  a_reset_quiet: assert property ($rose(rst_b) |-> !out_valid && !ctab_en && out_comp == '0
    && out_kind == pxt_k_frgba)
    else $error("outputs not cleared by reset");
  a_ready_comb: assert property (in_ready == (!out_valid || out_ready))
    else $error("in_ready does not follow output state");
  a_hold_stall: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_comp) && $stable(out_kind))
    else $error("result changed while stalled");
  a_take_answer: assert property (take |=> out_valid)
    else $error("taken group gave no result");
  a_irgba_pass: assert property (take && in_kind == pxt_k_irgba |=>
    out_kind == pxt_k_irgba && out_comp == $past(in_comp))
    else $error("integer quad modified");
  a_kind_legal: assert property (out_valid |-> out_kind <= pxt_k_ds)
    else $error("output kind outside the six kinds");
  a_cidx_keep: assert property (take && in_kind == pxt_k_cidx && dest == pxt_d_readback
    && readback_index_fmt |=> out_kind == pxt_k_cidx)
    else $error("index group lost its kind");
  a_cidx_conv: assert property (take && in_kind == pxt_k_cidx && dest == pxt_d_texture
    |=> out_kind == pxt_k_frgba)
    else $error("index group not converted for texture");
  a_depth_zero: assert property (take && in_kind == pxt_k_depth |=>
    out_kind == pxt_k_depth && out_comp[3:1] == '0)
    else $error("depth group has extra words");
  a_ctab_wr: assert property (ctab_en_wr |=> ctab_en == $past(ctab_en_wdata))
    else $error("colour table enable not written");
  a_ctab_hold: assert property (!ctab_en_wr |=> $stable(ctab_en))
    else $error("colour table enable changed unasked");
  c_conv: cover property (take && in_kind == pxt_k_cidx && dest == pxt_d_texture);
  c_stall: cover property (out_valid && !out_ready);
  c_ctab_on: cover property (ctab_en_wr && ctab_en_wdata);
endmodule // pxt_pipe_monitor
bind pxt_pipe pxt_pipe_monitor u_pxt_pipe_monitor (.*);
`default_nettype wire

// ==== tb/pxt_pipe_bench.sv ====
// Purpose: self-checking bench of the pixel transfer pipeline
// Assumes: one group in flight at a time, sink may stall
// Notes:   expected floats are exact powers of two and sums
`timescale 1ns/1ps
`default_nettype none
module pxt_pipe_bench;
  import pxt_pkg::*;
  localparam logic [31:0] F1 = 32'h3f80_0000, F2 = 32'h4000_0000, FH = 32'h3f00_0000;
  localparam logic [31:0] FQ = 32'h3e80_0000, F3Q = 32'h3f40_0000, F25 = 32'h4020_0000;
  localparam logic [3:0][31:0] CV = {FQ, F2, FH, F1};
  localparam logic [3:0][31:0] CT = {F2, F3Q, FH, FQ};
  logic ref_clk = 1'b0, rst_b = 1'b0, in_valid = 1'b0, in_idx_float = 1'b0, stall = 1'b0;
  logic map_color = 1'b0, map_stencil = 1'b0, raster_rgba = 1'b0, readback_index_fmt = 1'b0;
  logic ctab_en_wr = 1'b0, ctab_en_wdata = 1'b0, tab_wr_en = 1'b0;
  pxt_kind_t in_kind = pxt_k_frgba;
  pxt_kind_t out_kind;
  pxt_dest_t dest = pxt_d_readback;
  pxt_ctab_fmt_t ctab_fmt = pxt_f_rgba;
  logic [3:0][31:0] in_comp = '0, out_comp, ev;
  logic [4:0][31:0] scale_f = {5{F1}}, bias_f = '0;
  logic [5:0] index_shift = 6'h0;
  logic [15:0] index_offset = 16'h0;
  logic [4:0] ctab_width = 5'h10;
  logic [13:0][3:0] tab_size_m1 = {14{4'hf}};
  logic [3:0] tab_wr_sel = 4'h0, tab_wr_addr = 4'h0;
  logic [31:0] tab_wr_data = 32'h0;
  logic in_ready, out_valid, out_ready, ctab_en;
  logic [1:0] dsel [5] = '{2'h1, 2'h0, 2'h0, 2'h2, 2'h2};
  logic rr [5] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
  logic ri [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
  int num_errors = 0, tests_run = 0;
  always #10 ref_clk = ~ref_clk;
  pxt_pipe u_pxt_pipe (.*);
  pxt_sink_model u_pxt_sink_model (.ref_clk(ref_clk), .stall(stall), .out_ready(out_ready));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(input logic [3:0] s, input logic [3:0] a, input logic [31:0] d);
    tab_wr_en = 1'b1;
    tab_wr_sel = s;
    tab_wr_addr = a;
    tab_wr_data = d;
    tick;
    tab_wr_en = 1'b0;
    tick;
  endtask
  task automatic ctab(input logic v);
    ctab_en_wr = 1'b1;
    ctab_en_wdata = v;
    tick;
    ctab_en_wr = 1'b0;
    tick;
    chk({31'h0, ctab_en}, {31'h0, v});
  endtask
  // one group in, wait for its result under a bound, compare every word
  task automatic send(input pxt_kind_t k, input logic [3:0][31:0] c,
                      input pxt_kind_t ek, input logic [3:0][31:0] ex);
    int n;
    in_kind = k;
    in_comp = c;
    in_valid = 1'b1;
    n = 0;
    // hold the group until an edge at which the pipeline can take it
    while (in_ready !== 1'b1 && n < 20) begin
      tick;
      n++;
    end
    tick;
    in_valid = 1'b0;
    @(negedge ref_clk);
    while (!(out_valid === 1'b1 && out_ready === 1'b1) && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      conclude();
    end else begin
      chk({29'h0, out_kind}, {29'h0, ek});
      for (int i = 0; i < 4; i++) chk(out_comp[i], ex[i]);
      tick;
    end
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    #1 rst_b = 1'b1;
    chk({31'h0, out_valid}, 32'h0);
    chk({31'h0, ctab_en}, 32'h0);
    scale_f = {5{F2}};
    bias_f = {5{FH}};
    send(pxt_k_frgba, {4{F1}}, pxt_k_frgba, {4{F25}});
    send(pxt_k_depth, {96'h0, F1}, pxt_k_depth, {96'h0, F25});
    send(pxt_k_irgba, 128'h4_0000_0003_0000_0002_8000_0001, pxt_k_irgba,
         128'h4_0000_0003_0000_0002_8000_0001);
    scale_f = {5{F1}};
    bias_f = '0;
    readback_index_fmt = 1'b1;
    index_shift = 6'h01;
    index_offset = 16'h0002;
    send(pxt_k_cidx, 128'h3, pxt_k_cidx, 128'h0008_0000);
    index_shift = 6'h3f;
    send(pxt_k_cidx, 128'h3, pxt_k_cidx, 128'h0003_8000);
    index_shift = 6'h0;
    index_offset = 16'h0;
    in_idx_float = 1'b1;
    send(pxt_k_cidx, {96'h0, F2}, pxt_k_cidx, 128'h0002_0000);
    in_idx_float = 1'b0;
    wr(stencil_to_stencil_lut, 4'h3, 32'h2a);
    map_stencil = 1'b1;
    send(pxt_k_sidx, 128'h13, pxt_k_sidx, 128'h002a_0000);
    send(pxt_k_ds, {64'h0, 32'h13, F1}, pxt_k_ds, {64'h0, 32'h002a_0000, F1});
    map_stencil = 1'b0;
    send(pxt_k_sidx, 128'h13, pxt_k_sidx, 128'h0013_0000);
    wr(idx_to_idx_lut, 4'h5, 32'h40e0_0000);
    map_color = 1'b1;
    send(pxt_k_cidx, 128'h15, pxt_k_cidx, 128'h0007_0000);
    map_color = 1'b0;
    for (int i = 0; i < 4; i++) wr(4'(4 + i), 4'h5, CV[i]);
    for (int i = 0; i < 5; i++) begin
      dest = pxt_dest_t'(dsel[i]);
      raster_rgba = rr[i];
      readback_index_fmt = ri[i];
      if (i == 2 || i == 3) send(pxt_k_cidx, 128'h5, pxt_k_cidx, 128'h0005_0000);
      else send(pxt_k_cidx, 128'h5, pxt_k_frgba, CV);
    end
    for (int i = 0; i < 4; i++) begin
      wr(4'(i), 4'h8, FQ);
      wr(4'(i), 4'hf, F3Q);
    end
    map_color = 1'b1;
    send(pxt_k_frgba, {F2, FH, F2, FH}, pxt_k_frgba, {F3Q, FQ, F3Q, FQ});
    map_color = 1'b0;
    for (int i = 0; i < 4; i++) wr(4'(10 + i), 4'hf, CT[i]);
    ctab(1'b1);
    stall = 1'b1;
    for (int f = 0; f < 6; f++) begin
      ctab_fmt = pxt_ctab_fmt_t'(f);
      ev[0] = (f == 0) ? F1 : FQ;
      ev[1] = (f == 0) ? F1 : (f < 4) ? FQ : FH;
      ev[2] = (f == 0) ? F1 : (f < 4) ? FQ : F3Q;
      ev[3] = (f == 3) ? FQ : (f == 1 || f == 4) ? F1 : F2;
      send(pxt_k_frgba, {4{F1}}, pxt_k_frgba, ev);
    end
    ctab_width = 5'h0;
    send(pxt_k_frgba, {4{F1}}, pxt_k_frgba, {4{F1}});
    ctab_width = 5'h10;
    send(pxt_k_depth, {96'h0, F1}, pxt_k_depth, {96'h0, F1});
    ctab(1'b0);
    send(pxt_k_frgba, {4{F1}}, pxt_k_frgba, {4{F1}});
    stall = 1'b0;
    conclude();
  end
endmodule // pxt_pipe_bench
`default_nettype wire
